// ===== src/cds_clock_sleep.sv
`timescale 1ns/1ns
`include "cds_regs.svh"

// Contract
// - Unlock sets only when other bits zero
// - Unlock clears after four cycles or select write
// - Repeated unlock keeps original expiry
// - Divide by two to the code, max 256
// - Divided enable drives CPU and peripherals
// - Reset select from boot fuse
// - Any code writable after unlock
// - Sleep only when armed, chosen mode
// - Stall four cycles beyond startup on wake
// - Memories untouched across sleep
// - Reset during sleep restarts at vector
// - Low-power register at 0x33, layout, reset
// - Mode decode with two reserved codes
// - Idle halts only CPU and flash
// - Idle wakes on external or internal irq
// - Idle or noise mode starts conversion
// - Noise mode halts io, CPU, flash
// - Noise mode wakes only on listed events
// - New rate glitch-free, no faster step
// - Power-down stops every generated clock
// - Standby wakes in six cycles
module cds_clock_sleep
  import cds_pkg::*;
#(
  parameter int STARTUP_CYCLES = 6
)(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // Configuration
  input  wire logic       boot_divide_by_eight_fuse,
  input  wire logic       converter_enabled,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Core handshake
  input  wire logic       sleep_instr,
  input  wire logic       wake_irq_ext,
  input  wire logic       wake_irq_int,
  input  wire logic       wake_conv_done,
  input  wire logic       wake_reset_src,
  input  wire logic       wake_twi,
  input  wire logic       wake_timer2,
  input  wire logic       wake_mem_ready,
  input  wire logic       wake_level_irq_high,
  input  wire logic       wake_pin_change,
  input  wire logic       wake_watchdog,
  // Clock gates and status
  output logic            clk_cpu_en,
  output logic            clk_flash_en,
  output logic            clk_io_en,
  output logic            clk_adc_en,
  output logic            clk_asy_en,
  output logic            osc_en,
  output logic            core_stall,
  output logic            conv_start,
  output logic            sleeping
);

  initial
  begin
    // Start-up plus wake stall must fit the four-bit wake counter
    if (STARTUP_CYCLES < 1 || STARTUP_CYCLES > 11)
      $error("STARTUP_CYCLES out of range");
  end

  localparam logic [3:0] START_CNT = 4'(STARTUP_CYCLES);

  logic [3:0] sel_q;
  logic       unlock_q;
  logic [2:0] unlock_cnt_q;
  logic [2:0] mode_q;
  logic       arm_q;
  logic       boot_q;
  logic [7:0] div_cnt_q;
  logic       tick;
  cds_state_t state_q;
  cds_mode_t  slp_mode_q;
  logic [3:0] wake_cnt_q;
  logic       wr_cdr;
  logic       wr_lpc;
  logic       wake_ev;
  logic       sel_write;
  logic       unlock_write;

  assign wr_cdr       = reg_wr && reg_addr == `CDS_CDR_OFFSET;
  assign wr_lpc       = reg_wr && reg_addr == `CDS_LPC_OFFSET;
  assign unlock_write = wr_cdr && reg_wdata == 8'h80;
  assign sel_write    = wr_cdr && !reg_wdata[`CDS_UNLOCK_BIT];

  // Fuse sampled once after reset release
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      boot_q <= 1'b1;
    else
      boot_q <= 1'b0;
  end

  // Unlock window
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      unlock_q     <= 1'b0;
      unlock_cnt_q <= 3'h0;
    end
    else if (unlock_q)
    begin
      if (sel_write || unlock_cnt_q == `CDS_UNLOCK_CYCLES - 3'h1)
        unlock_q <= 1'b0;
      unlock_cnt_q <= unlock_cnt_q + 3'h1;
    end
    else if (unlock_write)
    begin
      unlock_q     <= 1'b1;
      unlock_cnt_q <= 3'h0;
    end
  end

  // Divider select
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      sel_q <= `CDS_SEL_RESET;
    else if (boot_q)
      sel_q <= boot_divide_by_eight_fuse ? `CDS_SEL_FUSE_RESET
                                         : `CDS_SEL_RESET;
    else if (sel_write && unlock_q)
      sel_q <= reg_wdata[3:0];
  end

  // Divider: tick when the low sel bits of counter wrap
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      div_cnt_q <= 8'h00;
    else
      div_cnt_q <= div_cnt_q + 8'h01;
  end

  always_comb
  begin
    logic [8:0] mask;
    mask = 9'h0;
    if (sel_q <= `CDS_SEL_MAX)
      mask = (9'h001 << sel_q) - 9'h001;
    else
      mask = 9'h0FF;
    // Tick only on counter alignment: glitch-free, never faster
    tick = (div_cnt_q & mask[7:0]) == mask[7:0];
  end

  // Low-power control register
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      mode_q <= 3'h0;
      arm_q  <= 1'b0;
    end
    else if (wr_lpc)
    begin
      mode_q <= reg_wdata[3:1];
      arm_q  <= reg_wdata[`CDS_ARM_BIT];
    end
  end

  // Read port
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (reg_rd && reg_addr == `CDS_LPC_OFFSET)
      reg_rdata <= {4'h0, mode_q, arm_q};
    else if (reg_rd && reg_addr == `CDS_CDR_OFFSET)
      reg_rdata <= {unlock_q, 3'h0, sel_q};
    else
      reg_rdata <= 8'h00;
  end

  // Wake decode per mode
  always_comb
  begin
    wake_ev = wake_reset_src || wake_twi || wake_level_irq_high ||
              wake_pin_change || wake_watchdog;
    unique case (slp_mode_q)
      CDS_IDLE:      wake_ev = wake_ev || wake_irq_ext || wake_irq_int ||
                               wake_conv_done || wake_timer2 ||
                               wake_mem_ready;
      CDS_NOISE_RED: wake_ev = wake_ev || wake_conv_done || wake_timer2 ||
                               wake_mem_ready;
      CDS_PWR_SAVE,
      CDS_EXT_STBY:  wake_ev = wake_ev || wake_timer2;
      default:       wake_ev = wake_ev;
    endcase
  end

  // Sleep sequencer; registers and memories are never touched here
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state_q    <= CDS_RUN;
      slp_mode_q <= CDS_IDLE;
      wake_cnt_q <= 4'h0;
    end
    else
    begin
      unique case (state_q)
        CDS_RUN:
          if (sleep_instr && arm_q && mode_q != 3'b100 &&
              mode_q != 3'b101)
          begin
            state_q    <= CDS_SLEEP;
            slp_mode_q <= cds_mode_t'(mode_q);
          end
        CDS_SLEEP:
          if (wake_ev)
          begin
            state_q <= CDS_WAKE;
            if (slp_mode_q == CDS_STANDBY || slp_mode_q == CDS_EXT_STBY)
              wake_cnt_q <= `CDS_STANDBY_WAKE + `CDS_WAKE_STALL;
            else
              wake_cnt_q <= START_CNT + `CDS_WAKE_STALL;
          end
        CDS_WAKE:
          if (wake_cnt_q == 4'h1)
            state_q <= CDS_RUN;
          else
            wake_cnt_q <= wake_cnt_q - 4'h1;
        default:
          state_q <= CDS_RUN;
      endcase
    end
  end

  // Clock gating outputs, all registered
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      clk_cpu_en   <= 1'b0;
      clk_flash_en <= 1'b0;
      clk_io_en    <= 1'b0;
      clk_adc_en   <= 1'b0;
      clk_asy_en   <= 1'b0;
      osc_en       <= 1'b1;
      core_stall   <= 1'b0;
      sleeping     <= 1'b0;
    end
    else
    begin
      sleeping   <= state_q == CDS_SLEEP;
      core_stall <= state_q != CDS_RUN;
      if (state_q == CDS_SLEEP)
      begin
        clk_cpu_en   <= 1'b0;
        clk_flash_en <= 1'b0;
        clk_io_en    <= tick && slp_mode_q == CDS_IDLE;
        clk_adc_en   <= tick && slp_mode_q <= CDS_NOISE_RED;
        clk_asy_en   <= slp_mode_q == CDS_IDLE ||
                        slp_mode_q == CDS_NOISE_RED ||
                        slp_mode_q == CDS_PWR_SAVE ||
                        slp_mode_q == CDS_EXT_STBY;
        osc_en       <= slp_mode_q != CDS_PWR_DOWN &&
                        slp_mode_q != CDS_PWR_SAVE;
      end
      else
      begin
        clk_cpu_en   <= tick && state_q == CDS_RUN;
        clk_flash_en <= tick && state_q == CDS_RUN;
        clk_io_en    <= tick;
        clk_adc_en   <= tick;
        clk_asy_en   <= 1'b1;
        osc_en       <= 1'b1;
      end
    end
  end

  // Conversion start on entry to idle or noise mode
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      conv_start <= 1'b0;
    else
      conv_start <= state_q == CDS_RUN && sleep_instr && arm_q &&
                    converter_enabled &&
                    (mode_q == 3'b000 || mode_q == 3'b001);
  end

  a_unlock_expiry: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(unlock_q) |-> ##[1:4] !unlock_q)
    else $error("unlock window too long");

  a_unlock_set: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(unlock_q) |-> $past(unlock_write))
    else $error("unlock set without clean write");

  a_sel_locked: assert property (@(posedge mclk) disable iff (!rst_n)
    (!unlock_q && !boot_q) |=> $stable(sel_q))
    else $error("select changed while locked");

  a_unarmed_no: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_q == CDS_RUN && sleep_instr && !arm_q) |=> state_q == CDS_RUN)
    else $error("slept while unarmed");

  a_reserved_no: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_q == CDS_RUN && (mode_q == 3'b100 || mode_q == 3'b101))
    |=> state_q == CDS_RUN)
    else $error("slept on reserved code");

  a_wake_stall: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_q == CDS_SLEEP && wake_ev && slp_mode_q == CDS_STANDBY)
    |=> (state_q == CDS_WAKE)[*8] ##1 (state_q == CDS_WAKE)
    ##1 (state_q == CDS_WAKE) ##1 state_q == CDS_RUN)
    else $error("standby wake length wrong");

  a_idle_gate: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_q == CDS_SLEEP) |=> !clk_cpu_en && !clk_flash_en)
    else $error("cpu clock ran in sleep");

  a_pd_osc: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_q == CDS_SLEEP && slp_mode_q == CDS_PWR_DOWN)
    |=> !osc_en && !clk_asy_en && !clk_io_en)
    else $error("power-down left a clock on");

  a_fuse_reset: assert property (@(posedge mclk) disable iff (!rst_n)
    boot_q |=> sel_q == (boot_divide_by_eight_fuse ? 4'h3 : 4'h0))
    else $error("fuse reset value wrong");

endmodule // cds_clock_sleep

// ===== src/cds_pkg.sv
package cds_pkg;
  typedef enum logic [2:0] {
    CDS_IDLE      = 3'b000,
    CDS_NOISE_RED = 3'b001,
    CDS_PWR_DOWN  = 3'b010,
    CDS_PWR_SAVE  = 3'b011,
    CDS_RSV4      = 3'b100,
    CDS_RSV5      = 3'b101,
    CDS_STANDBY   = 3'b110,
    CDS_EXT_STBY  = 3'b111
  } cds_mode_t;

  typedef enum logic [1:0] {
    CDS_RUN   = 2'b00,
    CDS_SLEEP = 2'b01,
    CDS_WAKE  = 2'b10
  } cds_state_t;
endpackage

// ===== src/cds_regs.svh
`ifndef CDS_REGS_SVH
`define CDS_REGS_SVH

// Register offsets
`define CDS_LPC_OFFSET      8'h33
`define CDS_CDR_OFFSET      8'h61
// Divider register fields
`define CDS_UNLOCK_BIT      7
`define CDS_SEL_W           4
`define CDS_SEL_RESET       4'h0
`define CDS_SEL_FUSE_RESET  4'h3
`define CDS_SEL_MAX         4'h8
// Low-power register fields
`define CDS_ARM_BIT         0
`define CDS_MODE_LSB        1
`define CDS_LPC_RESET       8'h00
// Timing
`define CDS_UNLOCK_CYCLES   3'h4
`define CDS_WAKE_STALL      4'h4
`define CDS_STANDBY_WAKE    4'h6
`define CDS_STARTUP_CYCLES  4'h6

`endif

// ===== verification/test_cds_clock_sleep.sv
`timescale 1ns/1ns
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin errors++; $display("unexpected %s exp %0h got %0h", n, e, a); end end

module test_cds_clock_sleep;
  localparam int SU = 3;
  // Per mode: register value, gates {cpu,flash,io,adc,osc}, wake source
  localparam logic [7:0] MV   [6] = '{8'h01, 8'h03, 8'h05, 8'h07, 8'h0D, 8'h0F};
  localparam logic [4:0] GT   [6] = '{5'h07, 5'h03, 5'h00, 5'h00, 5'h01, 5'h01};
  localparam int         WK   [6] = '{0, 2, 4, 5, 8, 9};
  localparam int         WAKE [6] = '{SU + 4, SU + 4, SU + 4, SU + 4, 10, 10};
  localparam logic [7:0] NOP  [3] = '{8'h00, 8'h09, 8'h0B};

  logic       mclk  = 1'h0;
  logic       rst_n = 1'h0;
  logic       fuse  = 1'h0;
  logic       wr    = 1'h0;
  logic       rd    = 1'h0;
  logic       slp   = 1'h0;
  logic [7:0] addr  = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [9:0] wk    = 10'h000;
  logic [7:0] rdata;
  logic [4:0] gates;
  logic       cpu, flash, io, adc, asy, osc, stall, cst, sleeping;
  int         errors     = 0;
  int         num_checks = 0;
  int         convs      = 0;

  cds_clock_sleep #(.STARTUP_CYCLES(SU)) DUT (
    .mclk(mclk), .rst_n(rst_n), .boot_divide_by_eight_fuse(fuse),
    .converter_enabled(1'h1), .reg_addr(addr), .reg_wdata(wdata),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .sleep_instr(slp),
    .wake_irq_ext(wk[0]), .wake_irq_int(wk[1]), .wake_conv_done(wk[2]),
    .wake_reset_src(wk[3]), .wake_twi(wk[4]), .wake_timer2(wk[5]),
    .wake_mem_ready(wk[6]), .wake_level_irq_high(wk[7]),
    .wake_pin_change(wk[8]), .wake_watchdog(wk[9]), .clk_cpu_en(cpu),
    .clk_flash_en(flash), .clk_io_en(io), .clk_adc_en(adc),
    .clk_asy_en(asy), .osc_en(osc), .core_stall(stall),
    .conv_start(cst), .sleeping(sleeping));

  assign gates = {cpu, flash, io, adc, osc};

  always #4 mclk = ~mclk;

  always @(posedge mclk)
    if (cst === 1'h1)
      convs++;

  task tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'h1;
    @(posedge mclk);
    wr    <= 1'h0;
  endtask

  task rd_chk(input logic [7:0] a, input logic [7:0] e);
    addr <= a;
    rd   <= 1'h1;
    @(posedge mclk);
    rd   <= 1'h0;
    #1;
    `CHK("read data", e, rdata)
    @(posedge mclk);
  endtask

  // Cycles up to the next cpu pulse, and io pulses seen meanwhile
  task gap(output int c, output int n);
    c = 0;
    n = 0;
    do
    begin
      @(negedge mclk);
      c++;
      n += int'(io === 1'h1);
    end
    while (cpu !== 1'h1 && c < 600);
  endtask

  task reset_dut;
    rst_n <= 1'h0;
    tick(2);
    rst_n <= 1'h1;
    tick(2);
  endtask

  task enter(input logic [7:0] v, input logic on);
    wr_reg(8'h33, v);
    slp <= 1'h1;
    @(posedge mclk);
    slp <= 1'h0;
    tick(2);
    #1;
    `CHK("sleeping", on, sleeping)
    `CHK("stall", on, stall)
    @(posedge mclk);
  endtask

  task print_verdict;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    #160000;
    errors++;
    $display("unexpected watchdog exp 0 got 1");
    print_verdict;
  end

  initial
  begin : main
    int c;
    int n;
    reset_dut;
    rd_chk(8'h61, 8'h00);
    rd_chk(8'h33, 8'h00);
    wr_reg(8'h33, 8'hFF);
    rd_chk(8'h33, 8'h0F);
    rd_chk(8'h40, 8'h00);
    $display("test registers done");
    wr_reg(8'h61, 8'h06);
    rd_chk(8'h61, 8'h00);
    wr_reg(8'h61, 8'h81);
    wr_reg(8'h61, 8'h02);
    rd_chk(8'h61, 8'h00);
    // Second unlock must not move the expiry
    wr_reg(8'h61, 8'h80);
    tick(2);
    wr_reg(8'h61, 8'h80);
    tick(2);
    wr_reg(8'h61, 8'h02);
    rd_chk(8'h61, 8'h00);
    wr_reg(8'h61, 8'h80);
    wr_reg(8'h61, 8'h80);
    wr_reg(8'h61, 8'h07);
    rd_chk(8'h61, 8'h07);
    wr_reg(8'h61, 8'h80);
    rd_chk(8'h61, 8'h87);
    tick(3);
    rd_chk(8'h61, 8'h07);
    $display("test unlock done");
    for (int k = 0; k < 10; k++)
    begin
      wr_reg(8'h61, 8'h80);
      wr_reg(8'h61, 8'(k));
      rd_chk(8'h61, 8'(k));
      gap(c, n);
      gap(c, n);
      gap(c, n);
      `CHK("divider period", (k > 8) ? 256 : 1 << k, c)
      `CHK("io pulses", 1, n)
      @(posedge mclk);
    end
    wr_reg(8'h61, 8'h80);
    wr_reg(8'h61, 8'h00);
    $display("test divider done");
    foreach (NOP[i])
      enter(NOP[i], 1'h0);
    for (int k = 0; k < 6; k++)
    begin
      n = convs;
      // Standby codes used as if a crystal is fitted
      // Comparator stays powered; its wake path is outside
      enter(MV[k], 1'h1);
      tick(2);
      @(negedge mclk);
      `CHK("gates", GT[k], gates)
      `CHK("conversions", int'(k < 2), convs - n)
      @(posedge mclk);
      // Idle irq is no wake source in noise mode
      wk <= (k == 1) ? 10'h002 : 10'h000;
      tick(4);
      #1;
      `CHK("still asleep", 1'h1, sleeping)
      @(posedge mclk);
      wk <= 10'h001 << WK[k];
      c = 0;
      do
      begin
        @(negedge mclk);
        c++;
      end
      while (stall === 1'h1 && c < 40);
      `CHK("wake stall", 1'h1, c > WAKE[k] && c < WAKE[k] + 4)
      @(posedge mclk);
      wk <= 10'h000;
    end
    $display("test sleep done");
    enter(8'h05, 1'h1);
    fuse <= 1'h1;
    reset_dut;
    #1;
    `CHK("sleeping", 1'h0, sleeping)
    `CHK("stall", 1'h0, stall)
    @(posedge mclk);
    rd_chk(8'h61, 8'h03);
    rd_chk(8'h33, 8'h00);
    $display("test reset done");
    print_verdict;
  end
endmodule // test_cds_clock_sleep
